// >>> rtl/led_fault_pkg.sv
// Purpose: Constants and types for the LED fault detection sequencer
// Assumes: 50 MHz system clock; serial pins sampled by that clock
// Notes:   APB register offsets and field layouts live here
//
// What this block does
// - Time bit picks 700ns or until gate rises
// - Current field 11 uses resistor, 10 small
// - Open detection starts only at strobe fall
// - Open/short start turns all sixteen channels on
// - Compare, then load flags into shift register
// - Flags shift out one per clock, data in
// - Short detection starts at strobe fall, outputs on
// - Short: output above threshold gives flag 0
// - Leakage needs gate high; outputs off, low flags 0
// - Gate toggle during leakage window leaves flags 1
// - Thermal loads 7FFF when hot, else FFFF
// - Overheat blocks transfer into output latch
// - Flags appear on serial output only once
// - Command is clock-edge count while strobe high
// - Flag 0 on error, 1 otherwise or invalid
// - Zero-power mode ignores all detection commands
package led_fault_pkg;

    localparam int CH_N    = 16;
    localparam int CNT_W   = 4;
    localparam int CLK_NS  = 20;
    localparam int WIN_NS  = 700;
    localparam int WIN_CYC = (WIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int TMR_W   = $clog2(WIN_CYC + 1);

    localparam logic [CNT_W-1:0] CMD_LATCH = 4'h0;
    localparam logic [CNT_W-1:0] CMD_OPEN  = 4'h1;
    localparam logic [CNT_W-1:0] CMD_SHORT = 4'h2;
    localparam logic [CNT_W-1:0] CMD_THERM = 4'h3;
    localparam logic [CNT_W-1:0] CMD_LEAK  = 4'h5;
    localparam logic [CNT_W-1:0] CNT_MAX   = 4'hf;

    localparam logic [1:0]      CUR_CURRENT_SET_RESISTOR  = 2'h3;
    localparam logic [1:0]      CUR_SMALL = 2'h2;
    localparam logic [CH_N-1:0] THERM_HOT = 16'h7fff;
    localparam logic [CH_N-1:0] ALL_ONES  = 16'hffff;
    localparam logic [CH_N-1:0] ALL_ZERO  = 16'h0000;

    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_RESULT = 12'h008;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_OS   = 2'b01,
        S_LK   = 2'b10
    } state_t;

    // CTRL register image: bit3 zero power, bits 2:1 current, bit0 time select
    typedef struct packed {
        logic       zero_power;
        logic [1:0] cur_sel;
        logic       time_sel;
    } cfg_t;

    localparam int   CFG_W   = $bits(cfg_t);
    localparam cfg_t CFG_RST = '{zero_power: 1'b0, cur_sel: CUR_SMALL, time_sel: 1'b0};

    // Every pin that crosses into the clock domain, synchronised as one bundle
    typedef struct packed {
        logic            sclk;
        logic            sdi;
        logic            strobe;
        logic            oe_n;
        logic            hot;
        logic [CH_N-1:0] open_cmp;
        logic [CH_N-1:0] short_cmp;
        logic [CH_N-1:0] leak_cmp;
    } pin_t;

endpackage : led_fault_pkg

// >>> rtl/led_fault_detect_sequencer.sv
// Purpose: Error detection sequencer and serial flag shifter of an LED sink driver
// Assumes: Serial pins are asynchronous and slower than a quarter of CLK_I
// Notes:   All state freezes while CE_I is low
`timescale 1ns/1ps

module led_fault_detect_sequencer
    import led_fault_pkg::*;
(
    // Clock, reset, enable
    input  wire logic            CLK_I,
    input  wire logic            SRST_I,
    input  wire logic            CE_I,
    // APB slave
    input  wire logic            PSEL_I,
    input  wire logic            PENABLE_I,
    input  wire logic            PWRITE_I,
    input  wire logic [11:0]     PADDR_I,
    input  wire logic [31:0]     PWDATA_I,
    output logic      [31:0]     PRDATA_O,
    output logic                 PREADY_O,
    output logic                 PSLVERR_O,
    // Serial link from the display controller
    input  wire logic            SCLK_I,
    input  wire logic            SDI_I,
    input  wire logic            LATCH_STROBE_I,
    input  wire logic            OE_N_I,
    output logic                 SERIAL_OUT_O,
    // Analog comparator and temperature flags
    input  wire logic [CH_N-1:0] OPEN_CMP_I,
    input  wire logic [CH_N-1:0] SHORT_CMP_I,
    input  wire logic [CH_N-1:0] LEAK_CMP_I,
    input  wire logic            OVERTEMP_I,
    // Output stage control
    output logic      [CH_N-1:0] CH_ON_O,
    output logic                 DET_FULL_CUR_O,
    output logic      [CH_N-1:0] OUT_LATCH_O
);

    pin_t                pins_meta;
    pin_t                pins;
    logic                sclk_prev;
    logic                strobe_prev;
    logic                oe_prev;
    logic                sclk_rise;
    logic                strobe_fall;
    logic                oe_rise;
    logic                oe_chg;
    logic [CNT_W-1:0]    edge_cnt;
    state_t              state;
    logic [TMR_W-1:0]    timer;
    logic                is_short;
    logic                leak_bad;
    logic                hot_block;
    logic [CH_N-1:0]     shreg;
    logic [CH_N-1:0]     result_hold;
    logic [CH_N-1:0]     next_flags;
    cfg_t                cfg;
    logic                detect_ok;
    logic                start_os;
    logic                start_lk;
    logic                os_end;
    logic                lk_end;
    logic                win_end;
    logic                apb_setup;
    logic                apb_access;

    // Two-stage synchroniser; the first stage feeds nothing but the second
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            pins_meta <= '0;
            pins      <= '0;
        end else if (CE_I) begin
            pins_meta <= '{sclk: SCLK_I, sdi: SDI_I, strobe: LATCH_STROBE_I, oe_n: OE_N_I,
                           hot: OVERTEMP_I, open_cmp: OPEN_CMP_I, short_cmp: SHORT_CMP_I,
                           leak_cmp: LEAK_CMP_I};
            pins      <= pins_meta;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            sclk_prev   <= 1'b0;
            strobe_prev <= 1'b0;
            oe_prev     <= 1'b0;
        end else if (CE_I) begin
            sclk_prev   <= pins.sclk;
            strobe_prev <= pins.strobe;
            oe_prev     <= pins.oe_n;
        end
    end

    assign sclk_rise   = pins.sclk & ~sclk_prev;
    assign strobe_fall = ~pins.strobe & strobe_prev;
    assign oe_rise     = pins.oe_n & ~oe_prev;
    assign oe_chg      = pins.oe_n ^ oe_prev;

    // Count serial clock edges while the strobe is high, saturating
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            edge_cnt <= CMD_LATCH;
        end else if (CE_I) begin
            if (strobe_fall) begin
                edge_cnt <= CMD_LATCH;
            end else if (pins.strobe && sclk_rise && edge_cnt != CNT_MAX) begin
                edge_cnt <= edge_cnt + 4'h1;
            end
        end
    end

    assign detect_ok = strobe_fall && !cfg.zero_power && state == S_IDLE;
    assign start_os  = detect_ok && (edge_cnt == CMD_OPEN || edge_cnt == CMD_SHORT);
    assign start_lk  = detect_ok && edge_cnt == CMD_LEAK && pins.oe_n;

    // Gate-timed end only applies to open and short; leakage is always fixed
    assign os_end  = state == S_OS &&
                     (cfg.time_sel ? oe_rise : timer == TMR_W'(WIN_CYC - 1));
    assign lk_end  = state == S_LK && timer == TMR_W'(WIN_CYC - 1);
    assign win_end = os_end || lk_end;

    // Comparators read once, at the closing cycle of the window
    always_comb begin
        next_flags = ALL_ONES;
        if (state == S_LK) begin
            if (leak_bad || oe_chg) begin
                next_flags = ALL_ONES;
            end else begin
                next_flags = ~pins.leak_cmp;
            end
        end else if (is_short) begin
            next_flags = ~pins.short_cmp;
        end else begin
            next_flags = ~pins.open_cmp;
        end
    end

    // Detection window sequencer
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            state    <= S_IDLE;
            timer    <= '0;
            is_short <= 1'b0;
            leak_bad <= 1'b0;
        end else if (CE_I) begin
            case (state)
                S_IDLE: begin
                    timer    <= '0;
                    leak_bad <= 1'b0;
                    if (start_os) begin
                        state    <= S_OS;
                        is_short <= edge_cnt == CMD_SHORT;
                    end else if (start_lk) begin
                        state <= S_LK;
                    end
                end
                S_OS: begin
                    if (timer != TMR_W'(WIN_CYC)) begin
                        timer <= timer + TMR_W'(1);
                    end
                    if (os_end) begin
                        state <= S_IDLE;
                    end
                end
                S_LK: begin
                    timer <= timer + TMR_W'(1);
                    if (oe_chg) begin
                        leak_bad <= 1'b1;
                    end
                    if (lk_end) begin
                        state <= S_IDLE;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // Shift register: window result beats thermal code beats a shift edge.
    // Bits shifted during a window are lost when the result lands there.
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            shreg <= ALL_ZERO;
        end else if (CE_I) begin
            if (win_end) begin
                shreg <= next_flags;
            end else if (strobe_fall && !cfg.zero_power && edge_cnt == CMD_THERM) begin
                shreg <= pins.hot ? THERM_HOT : ALL_ONES;
            end else if (sclk_rise) begin
                shreg <= {shreg[CH_N-2:0], pins.sdi};
            end
        end
    end

    // Top bit leaves first; flags are consumed by shifting, so they go out once
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            SERIAL_OUT_O <= 1'b0;
        end else if (CE_I) begin
            SERIAL_OUT_O <= shreg[CH_N-1];
        end
    end

    // Output latch, blocked after a thermal check found overheating
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            hot_block   <= 1'b0;
            OUT_LATCH_O <= ALL_ZERO;
        end else if (CE_I) begin
            if (strobe_fall && !cfg.zero_power && edge_cnt == CMD_THERM) begin
                hot_block <= pins.hot;
            end
            if (strobe_fall && edge_cnt == CMD_LATCH && !hot_block) begin
                OUT_LATCH_O <= shreg;
            end
        end
    end

    // Output stage drive: forced on or off in a window, data gated otherwise
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            CH_ON_O        <= ALL_ZERO;
            DET_FULL_CUR_O <= 1'b0;
            result_hold    <= ALL_ONES;
        end else if (CE_I) begin
            if (start_os || (state == S_OS && !os_end)) begin
                CH_ON_O        <= ALL_ONES;
                DET_FULL_CUR_O <= cfg.cur_sel == CUR_CURRENT_SET_RESISTOR;
            end else if (start_lk || (state == S_LK && !lk_end)) begin
                CH_ON_O        <= ALL_ZERO;
                DET_FULL_CUR_O <= 1'b0;
            end else begin
                CH_ON_O        <= pins.oe_n ? ALL_ZERO : OUT_LATCH_O;
                DET_FULL_CUR_O <= 1'b0;
            end
            if (win_end) begin
                result_hold <= next_flags;
            end
        end
    end

    // APB slave: one setup cycle, then a single access cycle with PREADY high
    assign apb_setup  = PSEL_I && !PENABLE_I && !PREADY_O;
    assign apb_access = PSEL_I && PENABLE_I && PREADY_O;

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O  <= 32'h0000_0000;
        end else if (CE_I) begin
            PREADY_O  <= apb_setup;
            PSLVERR_O <= 1'b0;
            PRDATA_O  <= 32'h0000_0000;
            if (apb_setup) begin
                if (PADDR_I == ADDR_CTRL) begin
                    PRDATA_O <= {28'h000_0000, cfg};
                end else if (PADDR_I == ADDR_STATUS) begin
                    PRDATA_O <= {30'h0000_0000, hot_block, state != S_IDLE};
                end else if (PADDR_I == ADDR_RESULT) begin
                    PRDATA_O <= {16'h0000, result_hold};
                end else begin
                    PSLVERR_O <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            cfg <= CFG_RST;
        end else if (CE_I) begin
            if (apb_access && PWRITE_I && PADDR_I == ADDR_CTRL) begin
                cfg <= cfg_t'(PWDATA_I[CFG_W-1:0]);
            end
        end
    end

    // Checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);

    sequence s_os_start;
        CE_I && start_os && !cfg.time_sel;
    endsequence

    sequence s_os_window;
        (state == S_OS && CH_ON_O == ALL_ONES) [*8];
    endsequence

    property p_os_on;
        s_os_start ##1 CE_I [*8] |-> ##1 s_os_window;
    endproperty
    a_os_on: assert property (p_os_on) else $error("channels not all on in window");

    property p_fixed_len;
        state == S_OS && !cfg.time_sel |-> timer <= TMR_W'(WIN_CYC - 1);
    endproperty
    a_fixed_len: assert property (p_fixed_len) else $error("fixed window overran");

    property p_gate_end;
        CE_I && state == S_OS && cfg.time_sel && oe_rise |=> state == S_IDLE;
    endproperty
    a_gate_end: assert property (p_gate_end) else $error("gate rise did not end window");

    property p_therm;
        CE_I && strobe_fall && !cfg.zero_power && edge_cnt == CMD_THERM && !win_end
            |=> shreg == ($past(pins.hot) ? THERM_HOT : ALL_ONES);
    endproperty
    a_therm: assert property (p_therm) else $error("thermal code wrong");

    property p_zero_power;
        CE_I && strobe_fall && cfg.zero_power && state == S_IDLE |=> state == S_IDLE;
    endproperty
    a_zero_power: assert property (p_zero_power) else $error("detection ran in zero power");

    property p_leak_bad;
        CE_I && lk_end && (leak_bad || oe_chg) |=> shreg == ALL_ONES;
    endproperty
    a_leak_bad: assert property (p_leak_bad) else $error("invalid leakage flags not 1");

    property p_short_flags;
        CE_I && os_end && is_short |=> shreg == ~$past(pins.short_cmp);
    endproperty
    a_short_flags: assert property (p_short_flags) else $error("short flags wrong");

    property p_hot_block;
        CE_I && hot_block |=> OUT_LATCH_O == $past(OUT_LATCH_O);
    endproperty
    a_hot_block: assert property (p_hot_block) else $error("latch moved while hot");

    property p_shift;
        CE_I && sclk_rise && !win_end && !strobe_fall
            |=> shreg == {$past(shreg[CH_N-2:0]), $past(pins.sdi)};
    endproperty
    a_shift: assert property (p_shift) else $error("shift register did not shift");

    property p_sout;
        CE_I |=> SERIAL_OUT_O == $past(shreg[CH_N-1]);
    endproperty
    a_sout: assert property (p_sout) else $error("serial output not top bit");

    property p_leak_off;
        state == S_LK && CE_I && !lk_end |=> CH_ON_O == ALL_ZERO;
    endproperty
    a_leak_off: assert property (p_leak_off) else $error("outputs on in leakage window");

endmodule : led_fault_detect_sequencer

// >>> test/ctrl_model.sv
// Purpose: Display controller model driving the serial link pins
// Assumes: Serial clock period of 8 system clocks (160 ns) in commands, 9 system clocks (180 ns) when shifting
// Notes:   Serial clock rests low outside frames and during windows
`timescale 1ns/1ps

module ctrl_model (
    // Clock
    input  wire logic clk_i,
    // Link pins
    input  wire logic so_i,
    output logic      sclk_o,
    output logic      sdi_o,
    output logic      strobe_o,
    output logic      oe_n_o
);
    initial begin
        sclk_o   = 1'b0;
        sdi_o    = 1'b0;
        strobe_o = 1'b0;
        oe_n_o   = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    // Four clocks per half period keeps the link under a quarter of the clock
    task automatic pulse();
        sclk_o <= 1'b1;
        tick(4);
        sclk_o <= 1'b0;
        tick(4);
    endtask : pulse

    // Edge count while the strobe is high selects the command
    task automatic command(input int n);
        strobe_o <= 1'b1;
        tick(4);
        repeat (n) pulse();
        strobe_o <= 1'b0;
        tick(1);
    endtask : command

    task automatic set_gate(input logic v);
        oe_n_o <= v;
        tick(1);
    endtask : set_gate

    // Reads a flag while the clock is low, then clocks in a new bit
    task automatic shift(input logic [15:0] din, output logic [15:0] dout);
        for (int i = 15; i >= 0; i--) begin
            sdi_o <= din[i];
            tick(4);
            @(negedge clk_i) dout[i] = so_i;
            @(posedge clk_i) sclk_o <= 1'b1;
            tick(4);
            sclk_o <= 1'b0;
        end
        // Idle data line shows the inverse, so a held copy is never mistaken
        sdi_o <= ~din[0];
        tick(4);
    endtask : shift
endmodule : ctrl_model

// >>> test/testbench.sv
// Purpose: Self-checking bench for the LED fault detection sequencer
// Assumes: Zero wait state APB slave; partner model owns the link pins
// Notes:   Every wait is bounded; all but count_win end the run when they expire
`timescale 1ns/1ps

module testbench;
    import led_fault_pkg::*;

    logic        clk, srst, ce, psel, penable, pwrite, pready, pslverr, overtemp;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        sclk, sdi, strobe, oe_n, sout, full_cur, er;
    logic [15:0] open_cmp, short_cmp, leak_cmp, ch_on, out_latch, sw;
    int          errors, check_count, n;

    led_fault_detect_sequencer dut_u (
        .CLK_I(clk), .SRST_I(srst), .CE_I(ce), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .SCLK_I(sclk), .SDI_I(sdi),
        .LATCH_STROBE_I(strobe), .OE_N_I(oe_n), .SERIAL_OUT_O(sout),
        .OPEN_CMP_I(open_cmp), .SHORT_CMP_I(short_cmp), .LEAK_CMP_I(leak_cmp),
        .OVERTEMP_I(overtemp), .CH_ON_O(ch_on), .DET_FULL_CUR_O(full_cur),
        .OUT_LATCH_O(out_latch)
    );

    ctrl_model ctl (
        .clk_i(clk), .so_i(sout), .sclk_o(sclk), .sdi_o(sdi), .strobe_o(strobe),
        .oe_n_o(oe_n)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic end_of_test();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic expired(input string what);
        errors++;
        $display("BAD %s expected completion seen timeout", what);
        end_of_test();
    endtask : expired

    // Request held from setup until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) expired("apb ready");
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0000_0000);
        chk(what, exp, rd);
        chk("slverr", 32'h0000_0000, {31'h0, er});
    endtask : rd_chk

    task automatic wait_ch(input logic [15:0] v);
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ch_on !== v && k < 40);
        if (k >= 40) expired("channel outputs");
    endtask : wait_ch

    // Counts cycles with every channel on
    task automatic count_win();
        n = 0;
        while (ch_on === 16'hffff && n < 400) begin
            @(posedge clk);
            n++;
        end
    endtask : count_win

    task automatic wait_idle();
        int k;
        ctl.tick(6);
        for (k = 0; k < 60; k++) begin
            apb(1'b0, ADDR_STATUS, 32'h0000_0000);
            if (rd[0] === 1'b0) break;
        end
        if (k >= 60) expired("window end");
    endtask : wait_idle

    initial begin
        srst = 1'b1; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0000_0000; overtemp = 1'b0;
        open_cmp = 16'h0000; short_cmp = 16'h0000; leak_cmp = 16'h0000;
        errors = 0; check_count = 0;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        rd_chk(ADDR_CTRL, 32'h0000_0004, "ctrl reset");
        rd_chk(ADDR_STATUS, 32'h0000_0000, "status reset");
        rd_chk(ADDR_RESULT, 32'h0000_ffff, "result reset");
        apb(1'b0, 12'hffc, 32'h0000_0000);
        chk("unmapped slverr", 32'h0000_0001, {31'h0, er});
        // Plain latch of shifted data, gate low
        ctl.shift(16'ha5c3, sw);
        ctl.command(0);
        ctl.tick(6);
        chk("latch", 32'h0000_a5c3, {16'h0, out_latch});
        chk("outputs", 32'h0000_a5c3, {16'h0, ch_on});
        // Open detection, default window and current
        open_cmp <= 16'h0081;
        ctl.command(1);
        wait_ch(16'hffff);
        chk("small current", 32'h0000_0000, {31'h0, full_cur});
        count_win();
        chk("window cycles", WIN_CYC, n);
        chk("outputs after", 32'h0000_a5c3, {16'h0, ch_on});
        ctl.shift(16'h1234, sw);
        chk("open flags", 32'h0000_ff7e, {16'h0, sw});
        rd_chk(ADDR_RESULT, 32'h0000_ff7e, "open result");
        ctl.shift(16'h0000, sw);
        chk("flags once", 32'h0000_1234, {16'h0, sw});
        // Short detection, gate-timed window, full current
        apb(1'b1, ADDR_CTRL, 32'hffff_fff7);
        short_cmp <= 16'h8001;
        ctl.command(2);
        wait_ch(16'hffff);
        chk("full current", 32'h0000_0001, {31'h0, full_cur});
        ctl.tick(60);
        chk("window held", 32'h0000_ffff, {16'h0, ch_on});
        ctl.set_gate(1'b1);
        count_win();
        chk("ends at gate", 32'h0000_0001, {31'h0, n < 8});
        rd_chk(ADDR_RESULT, 32'h0000_7ffe, "short result");
        // Leakage diagnosis with the gate held high
        apb(1'b1, ADDR_CTRL, 32'h0000_0004);
        leak_cmp <= 16'h0100;
        ctl.command(5);
        ctl.tick(8);
        chk("leak outputs off", 32'h0000_0000, {16'h0, ch_on});
        wait_idle();
        rd_chk(ADDR_RESULT, 32'h0000_feff, "leak result");
        // Gate toggling in the window leaves all flags high
        leak_cmp <= 16'hffff;
        ctl.command(5);
        ctl.tick(8);
        ctl.set_gate(1'b0);
        ctl.tick(4);
        ctl.set_gate(1'b1);
        wait_idle();
        rd_chk(ADDR_RESULT, 32'h0000_ffff, "leak invalid");
        // Fixed short window, stretched by a clock-enable pause
        short_cmp <= 16'h7ffe;
        ctl.command(2);
        wait_ch(16'hffff);
        ce <= 1'b0;
        ctl.tick(10);
        ce <= 1'b1;
        count_win();
        chk("paused window", WIN_CYC, n);
        rd_chk(ADDR_RESULT, 32'h0000_8001, "short fixed");
        // Thermal check, hot then normal
        overtemp <= 1'b1;
        ctl.command(3);
        ctl.tick(6);
        ctl.shift(16'h00ff, sw);
        chk("hot code", 32'h0000_7fff, {16'h0, sw});
        ctl.command(0);
        ctl.tick(6);
        chk("latch blocked", 32'h0000_a5c3, {16'h0, out_latch});
        overtemp <= 1'b0;
        ctl.command(3);
        ctl.tick(6);
        ctl.shift(16'h3c3c, sw);
        chk("normal code", 32'h0000_ffff, {16'h0, sw});
        ctl.command(0);
        ctl.tick(6);
        chk("latch again", 32'h0000_3c3c, {16'h0, out_latch});
        // Zero power ignores detection, configuration still works
        apb(1'b1, ADDR_CTRL, 32'h0000_000c);
        open_cmp <= 16'hff7e;
        ctl.command(1);
        ctl.tick(6);
        rd_chk(ADDR_STATUS, 32'h0000_0000, "zp idle");
        rd_chk(ADDR_RESULT, 32'h0000_8001, "zp result");
        rd_chk(ADDR_CTRL, 32'h0000_000c, "zp ctrl");
        end_of_test();
    end
endmodule : testbench
